/* logic/clock_supervision.v */
// Clock monitor, quality checker, self-clock mode, watchdog, tick and wait sequencer
//
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "clock_supervision_consts.vh"

module clock_supervision #(
  parameter WD_BASE = 10,
  parameter TICK_BASE = 8,
  parameter MON_CYC = `MON_DETECT_CYC
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Avalon-MM slave
  input wire [4:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output reg waitrequest,
  // Clock sources, sampled as levels
  input wire oscillator_clock,
  input wire vco_clock,
  // System events
  input wire por_event,
  input wire lvr_event,
  input wire full_stop,
  input wire pseudo_stop,
  input wire wait_instruction,
  input wire ext_wake,
  // Clock and power control
  output reg pll_enable,
  output reg voltage_regulator_enable,
  output reg pll_select,
  output reg self_clock_mode,
  output reg core_clk_en,
  output reg sys_clk_en,
  output reg osc_reduce,
  output reg wait_active,
  // Interrupts, wake-up and resets
  output reg tick_irq,
  output reg self_clock_irq,
  output reg wake,
  output reg monitor_fail_reset,
  output reg watchdog_reset
);

  localparam [31:0] MON_LIMIT = MON_CYC;

  reg [`CTRL_W-1:0] ctrl_reg;
  reg [7:0] wdog_ctrl_reg;
  reg [2:0] tick_rate_reg;
  reg self_clock_flag_reg, tick_flag_reg, scm_reg, mon_fail_reg;
  reg osc_prev_reg, vco_prev_reg;
  reg [31:0] mon_cnt_reg;
  reg checking_reg;
  reg [15:0] win_cnt_reg;
  reg [12:0] osc_cnt_reg;
  reg [31:0] wd_cnt_reg;
  reg wd_armed_reg;
  reg [31:0] tick_cnt_reg;
  reg [2:0] wstate_reg;
  reg full_stop_prev_reg;

  wire osc_rise = oscillator_clock & ~osc_prev_reg;
  wire vco_rise = vco_clock & ~vco_prev_reg;
  wire in_wait = (wstate_reg != `WS_RUN);
  wire [2:0] wd_rate = wdog_ctrl_reg[`WD_RATE_MSB:0];
  wire wd_window = wdog_ctrl_reg[`WD_WINDOW_BIT];
  wire [31:0] wd_period = 32'h1 << (WD_BASE + 2 * wd_rate);
  wire [31:0] tick_period = 32'h1 << (TICK_BASE + tick_rate_reg);

  // Bus access decode, taken at the edge that sees waitrequest low
  wire bus_wr = write & ~waitrequest;
  wire wr_ctrl = bus_wr & (address == `OFS_CONTROL);
  wire wr_stat = bus_wr & (address == `OFS_STATUS);
  wire wr_wdc = bus_wr & (address == `OFS_WDOG_CTRL);
  wire wr_rst = bus_wr & (address == `OFS_WDOG_RESTART);
  wire wr_tick = bus_wr & (address == `OFS_TICK_RATE);

  // Clock monitor
  // (R1) missing edge detect
  wire mon_timeout = ctrl_reg[`CB_MON_EN] & (mon_cnt_reg >= MON_LIMIT);
  wire mon_event = mon_timeout & ~mon_fail_reg;
  wire sc_allowed = ctrl_reg[`CB_MON_EN] & ctrl_reg[`CB_SC_EN];
  // (R16) both enables required
  wire scm_enter = mon_event & sc_allowed;
  // (R21) reset when self-clock off
  wire mon_reset = mon_event & ~ctrl_reg[`CB_SC_EN];

  // Quality checker
  wire full_stop_exit = full_stop_prev_reg & ~full_stop;
  // (R2) check trigger sources
  wire check_start = por_event | lvr_event | full_stop_exit | mon_event;
  // (R4) ok ends window at once
  wire osc_ok = checking_reg & osc_rise & (osc_cnt_reg == `OSC_OK_EDGES - 13'd1);

  // Watchdog
  wire wd_run = (wd_rate != 3'd0) &
                ~(in_wait & ctrl_reg[`CB_WDOG_WAIT]) &
                ~(pseudo_stop & ~ctrl_reg[`CB_WDOG_PSTOP]) & ~full_stop;
  // (R8) expiry request
  wire wd_expire = wd_run & osc_rise & (wd_cnt_reg >= wd_period - 32'h1);
  wire wd_early = wd_window & (wd_cnt_reg < wd_period - (wd_period >> 2));
  wire key_first = (writedata[15:0] == `WD_KEY_FIRST);
  wire key_second = (writedata[15:0] == `WD_KEY_SECOND);
  // (R23) ignored while stopped
  wire wd_wr_live = wr_rst & (wd_rate != 3'd0);
  // (R10) bad key, (R11) early write
  wire wd_bad = wd_wr_live & (~(key_first | key_second) | wd_early);
  // (R9) key pair restarts period
  wire wd_restart = wd_wr_live & ~wd_bad & key_second & wd_armed_reg;
  wire wd_reset_now = wd_bad | wd_expire;

  // Tick
  // (R12) pseudo-stop run, (R15) zero stops
  wire tick_run = (tick_rate_reg != 3'd0) &
                  ~(in_wait & ctrl_reg[`CB_TICK_WAIT]) &
                  ~(pseudo_stop & ~ctrl_reg[`CB_TICK_PSTOP]) & ~full_stop;
  wire tick_end = tick_run & osc_rise & (tick_cnt_reg >= tick_period - 32'h1);

  // Wake sources
  wire sc_irq_now = scm_enter & ctrl_reg[`CB_SC_IRQ_EN];
  wire tick_irq_now = tick_end & ctrl_reg[`CB_TICK_IRQ_EN];
  wire any_reset = mon_reset | wd_reset_now;
  // (R20) wait exit sources
  wire wake_now = sc_irq_now | tick_irq_now | ext_wake | any_reset;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      readdata <= 32'h0;
      waitrequest <= 1'b1;
      osc_prev_reg <= 1'b0;
      vco_prev_reg <= 1'b0;
      full_stop_prev_reg <= 1'b0;
      mon_cnt_reg <= 32'h0;
      mon_fail_reg <= 1'b0;
    end else begin
      // One wait state per access
      if ((read | write) & waitrequest) begin
        waitrequest <= 1'b0;
      end else begin
        waitrequest <= 1'b1;
      end
      readdata <= 32'h0;
      if (read & waitrequest) begin
        case (address)
          `OFS_CONTROL: readdata <= {{(32-`CTRL_W){1'b0}}, ctrl_reg};
          `OFS_STATUS: readdata <= {26'h0, mon_fail_reg, wstate_reg == `WS_WAIT,
                                    checking_reg, scm_reg, tick_flag_reg,
                                    self_clock_flag_reg};
          `OFS_WDOG_CTRL: readdata <= {24'h0, wdog_ctrl_reg};
          `OFS_TICK_RATE: readdata <= {29'h0, tick_rate_reg};
          // (R23) restart register reads zero
          default: readdata <= 32'h0;
        endcase
      end
      osc_prev_reg <= oscillator_clock;
      vco_prev_reg <= vco_clock;
      full_stop_prev_reg <= full_stop;
      // Failure stays latched until edges return, so one event per loss
      if (osc_rise) begin
        mon_cnt_reg <= 32'h0;
        mon_fail_reg <= 1'b0;
      end else begin
        if (mon_cnt_reg < MON_LIMIT) begin
          mon_cnt_reg <= mon_cnt_reg + 32'h1;
        end
        if (mon_timeout) begin
          mon_fail_reg <= 1'b1;
        end
      end
    end
  end

  // Quality checker runs independently of reset handling
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      // Power-up always begins with a check
      checking_reg <= 1'b1;
      win_cnt_reg <= 16'h0;
      osc_cnt_reg <= 13'h0;
    end else begin
      // (R6) check continues in parallel
      if (check_start) begin
        checking_reg <= 1'b1;
        win_cnt_reg <= 16'h0;
        osc_cnt_reg <= 13'h0;
      end else if (full_stop) begin
        // Full stop abandons the check; exit starts a fresh window
        checking_reg <= 1'b0;
      end else if (checking_reg) begin
        if (osc_ok) begin
          checking_reg <= 1'b0;
        // (R3) window length in VCO cycles
        end else if (vco_rise & (win_cnt_reg == `CHECK_WINDOW_VCO - 16'd1)) begin
          win_cnt_reg <= 16'h0;
          osc_cnt_reg <= 13'h0;
        end else begin
          if (vco_rise) begin
            win_cnt_reg <= win_cnt_reg + 16'd1;
          end
          if (osc_rise) begin
            osc_cnt_reg <= osc_cnt_reg + 13'd1;
          end
        end
      end
    end
  end

  // Registers, flags, watchdog, tick and wait sequencer
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_reg <= `CTRL_RESET;
      // (R8) watchdog off out of reset
      wdog_ctrl_reg <= 8'h00;
      tick_rate_reg <= 3'd0;
      self_clock_flag_reg <= 1'b0;
      tick_flag_reg <= 1'b0;
      scm_reg <= 1'b0;
      wd_cnt_reg <= 32'h0;
      wd_armed_reg <= 1'b0;
      tick_cnt_reg <= 32'h0;
      wstate_reg <= `WS_RUN;
    end else if (any_reset) begin
      // Internal reset restores defaults like an external one, except scm_reg and self-clock enable
      ctrl_reg <= `CTRL_RESET;
      // (R7) monitor reset sets self-clock enable
      ctrl_reg[`CB_SC_EN] <= 1'b1;
      wdog_ctrl_reg <= 8'h00;
      tick_rate_reg <= 3'd0;
      self_clock_flag_reg <= 1'b0;
      tick_flag_reg <= 1'b0;
      wd_cnt_reg <= 32'h0;
      wd_armed_reg <= 1'b0;
      tick_cnt_reg <= 32'h0;
      wstate_reg <= `WS_RUN;
      if (wd_reset_now & ~mon_reset) begin
        ctrl_reg[`CB_SC_EN] <= 1'b0;
      end
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= writedata[`CTRL_W-1:0];
      end
      if (wr_wdc) begin
        wdog_ctrl_reg <= {writedata[`WD_WINDOW_BIT], 4'h0, writedata[`WD_RATE_MSB:0]};
      end
      // Set wins over write-one-to-clear
      self_clock_flag_reg <= scm_enter |
                             (self_clock_flag_reg & ~(wr_stat & writedata[`SB_SC_FLAG]));
      // (R13) flag set at period end
      tick_flag_reg <= tick_end | (tick_flag_reg & ~(wr_stat & writedata[`SB_TICK_FLAG]));

      // (R16) enter self-clock mode, drop PLL
      if (scm_enter) begin
        scm_reg <= 1'b1;
        ctrl_reg[`CB_PLL_SEL] <= 1'b0;
      // (R17) return to oscillator
      end else if (osc_ok) begin
        scm_reg <= 1'b0;
      end

      // Watchdog counter on oscillator edges
      if (wd_restart | wr_wdc) begin
        wd_cnt_reg <= 32'h0;
      end else if (wd_run & osc_rise) begin
        wd_cnt_reg <= wd_cnt_reg + 32'h1;
      end
      // (R24) repeated first keys only re-arm; unarmed second keys ignored
      if (wd_restart | (wd_rate == 3'd0)) begin
        wd_armed_reg <= 1'b0;
      end else if (wd_wr_live & key_first) begin
        wd_armed_reg <= 1'b1;
      end

      // (R14) rate write restarts period
      if (wr_tick) begin
        tick_rate_reg <= writedata[`TICK_RATE_MSB:0];
        tick_cnt_reg <= 32'h0;
      end else if (tick_end) begin
        tick_cnt_reg <= 32'h0;
      end else if (tick_run & osc_rise) begin
        tick_cnt_reg <= tick_cnt_reg + 32'h1;
      end

      // (R19) ordered wait entry
      case (wstate_reg)
        `WS_RUN: begin
          if (wait_instruction) begin
            wstate_reg <= `WS_SEL;
          end
        end
        `WS_SEL: begin
          if (ctrl_reg[`CB_PLL_WAIT]) begin
            ctrl_reg[`CB_PLL_SEL] <= 1'b0;
          end
          wstate_reg <= wake_now ? `WS_RUN : `WS_PLL;
        end
        `WS_PLL: wstate_reg <= wake_now ? `WS_RUN : `WS_CORE;
        `WS_CORE: wstate_reg <= wake_now ? `WS_RUN : `WS_SYS;
        `WS_SYS: wstate_reg <= wake_now ? `WS_RUN : `WS_WAIT;
        `WS_WAIT: begin
          // (R21) wake only if self-clock irq enabled; (R22) immediate resume
          if (wake_now) begin
            wstate_reg <= `WS_RUN;
          end
        end
        default: wstate_reg <= `WS_RUN;
      endcase
    end
  end

  // Registered outputs
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      pll_enable <= 1'b1;
      voltage_regulator_enable <= 1'b1;
      pll_select <= 1'b0;
      self_clock_mode <= 1'b0;
      core_clk_en <= 1'b1;
      sys_clk_en <= 1'b1;
      osc_reduce <= 1'b0;
      wait_active <= 1'b0;
      tick_irq <= 1'b0;
      self_clock_irq <= 1'b0;
      wake <= 1'b0;
      monitor_fail_reset <= 1'b0;
      watchdog_reset <= 1'b0;
    end else begin
      // (R5) check keeps PLL and regulator up; (R18) wait stops
      pll_enable <= checking_reg | scm_reg |
                    ~(ctrl_reg[`CB_PLL_WAIT] & (wstate_reg >= `WS_PLL));
      voltage_regulator_enable <= checking_reg | scm_reg | ~pseudo_stop;
      pll_select <= ctrl_reg[`CB_PLL_SEL];
      self_clock_mode <= scm_reg;
      core_clk_en <= ~((ctrl_reg[`CB_CORE_WAIT] | ctrl_reg[`CB_SYS_WAIT]) &
                       (wstate_reg >= `WS_CORE));
      sys_clk_en <= ~(ctrl_reg[`CB_SYS_WAIT] & (wstate_reg >= `WS_SYS));
      osc_reduce <= ctrl_reg[`CB_OSC_RED_WAIT] & (wstate_reg == `WS_WAIT);
      wait_active <= (wstate_reg == `WS_WAIT);
      tick_irq <= tick_flag_reg & ctrl_reg[`CB_TICK_IRQ_EN];
      self_clock_irq <= self_clock_flag_reg & ctrl_reg[`CB_SC_IRQ_EN];
      wake <= in_wait & wake_now;
      monitor_fail_reset <= mon_reset;
      watchdog_reset <= wd_reset_now;
    end
  end

endmodule
`default_nettype wire

/* logic/clock_supervision_consts.vh */
// Constants for the clock supervision, watchdog, tick and wait-mode block
// Behaviour
// (R1) Monitor enabled: missing oscillator edges flag failure; self-clock mode or system reset.
// (R2) Quality check starts on power-on, low-voltage, full stop exit, monitor failure.
// (R3) Each check window lasts 50000 VCO clock cycles.
// (R4) 4096 oscillator rising edges inside a window mean good; window ends at once.
// (R5) Running check keeps PLL and voltage regulator enabled, even in pseudo-stop or wait.
// (R6) Quality check keeps running alongside self-clock or monitor reset handling.
// (R7) Monitor reset always leaves self-clock enable set to one.
// (R8) Watchdog off after reset; expiry of selected period requests system reset.
// (R9) Software writes key 0x0055 then 0x00aa within period to restart it.
// (R10) Restart register write of any other value resets immediately.
// (R11) Windowed mode: restart writes only in last quarter of period, else reset.
// (R12) Watchdog and tick keep counting in pseudo-stop when their run bits set.
// (R13) Tick period end sets tick flag, restarts period, interrupts if enabled.
// (R14) Any write to tick rate control restarts the tick period.
// (R15) Three-bit watchdog rate gives seven periods; zero stops it; zero tick rate stops tick.
// (R16) Self-clock mode needs both enables; runs from VCO; clears PLL select.
// (R17) Oscillator found good again: back to oscillator clock, self-clock mode left.
// (R18) Wait bits independently stop PLL, core, system, tick, watchdog, reduce oscillator; here the system wait bit also stops the core clock.
// (R19) Wait entry: clear PLL select, stop PLL, core, then system clocks; then active.
// (R20) Wait left on external, monitor, watchdog reset, self-clock or tick interrupt.
// (R21) Wait-mode failure: reset if self-clock off, else flag, enter mode, wake if enabled.
// (R22) Other interrupt wakes at once; PLL select stays cleared if PLL was stopped.
// (R23) Watchdog stopped: restart writes ignored; restart register always reads zero.
// (R24) Repeated first or second keys tolerated; only first-then-second restarts.
`ifndef CLOCK_SUPERVISION_CONSTS_VH
`define CLOCK_SUPERVISION_CONSTS_VH

// Register byte offsets
`define OFS_CONTROL 5'h00
`define OFS_STATUS 5'h04
`define OFS_WDOG_CTRL 5'h08
`define OFS_WDOG_RESTART 5'h0c
`define OFS_TICK_RATE 5'h10

// Control register bits
`define CB_MON_EN 0
`define CB_SC_EN 1
`define CB_SC_IRQ_EN 2
`define CB_PLL_SEL 3
`define CB_TICK_IRQ_EN 4
`define CB_PLL_WAIT 5
`define CB_CORE_WAIT 6
`define CB_SYS_WAIT 7
`define CB_TICK_WAIT 8
`define CB_WDOG_WAIT 9
`define CB_OSC_RED_WAIT 10
`define CB_WDOG_PSTOP 11
`define CB_TICK_PSTOP 12
`define CTRL_W 13
`define CTRL_RESET 13'h0000

// Status register bits
`define SB_SC_FLAG 0
`define SB_TICK_FLAG 1
`define SB_SC_MODE 2
`define SB_CHECKING 3
`define SB_WAIT 4
`define SB_MON_FAIL 5

// Watchdog control fields
`define WD_RATE_MSB 2
`define WD_WINDOW_BIT 7

// Tick rate field
`define TICK_RATE_MSB 2

// Restart keys
`define WD_KEY_FIRST 16'h0055
`define WD_KEY_SECOND 16'h00aa

// Quality checker
`define CHECK_WINDOW_VCO 16'd50000
`define OSC_OK_EDGES 13'd4096

// Clock monitor detection time
`define CLK_PERIOD_NS 100
`define MON_DETECT_NS 100000
`define MON_DETECT_CYC (`MON_DETECT_NS / `CLK_PERIOD_NS)

// Wait sequencer states
`define WS_RUN 3'd0
`define WS_SEL 3'd1
`define WS_PLL 3'd2
`define WS_CORE 3'd3
`define WS_SYS 3'd4
`define WS_WAIT 3'd5

`endif

/* sim/clock_supervision_chk.sv */
// Port-level checker for the clock supervision block
`timescale 1ns/1ps
`default_nettype none
module clock_supervision_chk #(
  parameter WD_BASE = 10,
  parameter TICK_BASE = 8,
  parameter MON_CYC = 1000
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Bus
  input wire [4:0] address,
  input wire read,
  input wire write,
  input wire [31:0] readdata,
  input wire waitrequest,
  // Sources and events
  input wire oscillator_clock,
  input wire wait_instruction,
  input wire ext_wake,
  // Control and resets
  input wire pll_enable,
  input wire voltage_regulator_enable,
  input wire pll_select,
  input wire self_clock_mode,
  input wire wait_active,
  input wire tick_irq,
  input wire wake,
  input wire monitor_fail_reset,
  input wire watchdog_reset
);
  reg osc_q_reg;
  reg [15:0] gap_reg;
  reg wrote_reg;
  // Cycles since last oscillator rise; wraps are harmless at bench lengths
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      osc_q_reg <= 1'b0;
      gap_reg <= 16'h0000;
      wrote_reg <= 1'b0;
    end else begin
      osc_q_reg <= oscillator_clock;
      gap_reg <= (oscillator_clock && !osc_q_reg) ? 16'h0000 : gap_reg + 16'h0001;
      if (write && !waitrequest) wrote_reg <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered next cycle");
  chk_ack_single: assert property (!waitrequest |=> waitrequest)
    else $error("answer longer than one cycle");
  chk_restart_zero: assert property (read && !waitrequest && address == 5'h0c
    |-> readdata == 0)
    else $error("restart register read not zero");
  chk_wd_boot_quiet: assert property (!wrote_reg |-> !watchdog_reset)
    else $error("watchdog reset before any setup");
  chk_tick_boot_quiet: assert property (!wrote_reg |-> !tick_irq)
    else $error("tick interrupt before any setup");
  chk_sc_power: assert property (self_clock_mode |-> pll_enable && voltage_regulator_enable)
    else $error("self-clock mode without pll or regulator");
  chk_sc_pll_clear: assert property ($rose(self_clock_mode) |-> ##[0:2] !pll_select)
    else $error("pll select kept in self-clock mode");
  chk_mon_gap: assert property (monitor_fail_reset || $rose(self_clock_mode)
    |-> gap_reg >= MON_CYC - 2)
    else $error("monitor failure while oscillator alive");
  chk_wait_order: assert property ($rose(wait_active)
    |-> $past(wait_instruction, 5) || $past(wait_instruction, 6))
    else $error("wait entry not after the clock sequence");
  chk_wake_prompt: assert property (ext_wake && wait_active |-> ##[1:3] wake)
    else $error("no prompt wake on interrupt");
  chk_wd_pulse: assert property (watchdog_reset |=> !watchdog_reset)
    else $error("watchdog reset pulse too long");
  cover property ($rose(wait_active));
  cover property (wake);
  cover property (watchdog_reset);
  cover property ($rose(self_clock_mode));
endmodule
bind clock_supervision clock_supervision_chk #(.WD_BASE(WD_BASE), .TICK_BASE(TICK_BASE),
  .MON_CYC(MON_CYC)) clock_supervision_chk_inst (.clk_sys, .rst_n, .address, .read, .write,
  .readdata, .waitrequest, .oscillator_clock, .wait_instruction, .ext_wake, .pll_enable,
  .voltage_regulator_enable, .pll_select, .self_clock_mode, .wait_active, .tick_irq, .wake,
  .monitor_fail_reset, .watchdog_reset);
`default_nettype wire

/* sim/tb_clock_supervision.sv */
// Self-checking bench for the clock supervision block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_clock_supervision;
  localparam int WDB = 2, TKB = 1, MON = 8;
  logic clk_sys, rst_n = 0, read = 0, write = 0, oscillator_clock = 0, vco_clock = 0;
  logic wait_instruction = 0, ext_wake = 0, osc_run = 1, por_event = 0, pseudo_stop = 0;
  logic [4:0] address = 0;
  logic [31:0] writedata = 0, q, seed = 32'h19f6ddde;
  logic [15:0] k;
  wire [31:0] readdata;
  wire waitrequest, pll_enable, voltage_regulator_enable, pll_select, self_clock_mode, core_clk_en;
  wire sys_clk_en, osc_reduce, wait_active, tick_irq, self_clock_irq, wake;
  wire monitor_fail_reset, watchdog_reset;
  int err_count = 0, compares = 0, wd_hits = 0, n, h, i, r;
  clock_supervision #(.WD_BASE(WDB), .TICK_BASE(TKB), .MON_CYC(MON)) clock_supervision_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .oscillator_clock(oscillator_clock), .vco_clock(vco_clock), .por_event(por_event),
    .lvr_event(1'b0), .full_stop(1'b0), .pseudo_stop(pseudo_stop),
    .wait_instruction(wait_instruction),
    .ext_wake(ext_wake), .pll_enable(pll_enable), .voltage_regulator_enable(voltage_regulator_enable),
    .pll_select(pll_select), .self_clock_mode(self_clock_mode), .core_clk_en(core_clk_en),
    .sys_clk_en(sys_clk_en), .osc_reduce(osc_reduce), .wait_active(wait_active),
    .tick_irq(tick_irq), .self_clock_irq(self_clock_irq), .wake(wake),
    .monitor_fail_reset(monitor_fail_reset), .watchdog_reset(watchdog_reset));
  initial begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Oscillator rises every second cycle; stopping it models clock loss
  always @(posedge clk_sys) begin
    vco_clock <= ~vco_clock;
    if (osc_run) oscillator_clock <= ~oscillator_clock;
    if (watchdog_reset === 1'b1) wd_hits <= wd_hits + 1;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int wd_cyc(input int rt);
    return 2 * (1 << (WDB + 2 * rt));
  endfunction
  function automatic int tk_cyc(input int rt);
    return 2 * (1 << (TKB + rt));
  endfunction
  function automatic logic sig(input int w);
    case (w)
      0: return watchdog_reset;
      1: return monitor_fail_reset;
      2: return tick_irq;
      3: return wait_active;
      4: return wake;
      default: return !self_clock_mode;
    endcase
  endfunction
  task automatic wait_sig(input int w, input int lim, output int cnt);
    cnt = 0;
    @(posedge clk_sys);
    while (sig(w) !== 1'b1 && cnt < lim) begin
      @(posedge clk_sys);
      cnt++;
    end
  endtask
  task automatic bus(input logic wr_en, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    address <= a;
    writedata <= d;
    write <= wr_en;
    read <= !wr_en;
    @(posedge clk_sys);
    while (waitrequest !== 1'b0) @(posedge clk_sys);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk_sys);
  endtask
  task automatic pulse_wait;
    @(posedge clk_sys) wait_instruction <= 1'b1;
    @(posedge clk_sys) wait_instruction <= 1'b0;
  endtask
  task automatic finish_test;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    idle(40000);
    err_count++;
    finish_test;
  end
  initial begin
    idle(6);
    rst_n <= 1'b1;
    bus(0, 5'h08, 0); `CHK(q, 32'h0)
    wr(5'h14, 32'hffffffff); bus(0, 5'h14, 0); `CHK(q, 32'h0)
    h = wd_hits; wr(5'h0c, 32'h1234); idle(40); `CHK(wd_hits, h)
    bus(0, 5'h0c, 0); `CHK(q, 32'h0)
    for (i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      k = (seed[15:0] == 16'h0055 || seed[15:0] == 16'h00aa) ? 16'h0001 : seed[15:0];
      wr(5'h08, 32'h1); wr(5'h0c, {16'h0, k}); wait_sig(0, 6, n); `CHK(n < 6, 1'b1)
    end
    wr(5'h08, 32'h1); h = wd_hits;
    for (i = 0; i < 6; i++) begin
      wr(5'h0c, 32'h55); wr(5'h0c, 32'h55); wr(5'h0c, 32'haa); wr(5'h0c, 32'haa);
      seed = lfsr(seed);
      idle(2 + seed[2:0]);
    end
    `CHK(wd_hits, h)
    wait_sig(0, 40, n); `CHK(n < 40, 1'b1)
    for (r = 1; r < 4; r++) begin
      wr(5'h08, r); wait_sig(0, 2000, n);
      `CHK(n >= wd_cyc(r) - 4 && n <= wd_cyc(r) + 4, 1'b1)
    end
    wr(5'h08, 32'h82); wr(5'h0c, 32'h55); wait_sig(0, 6, n); `CHK(n < 6, 1'b1)
    wr(5'h08, 32'h82); idle(wd_cyc(2) * 3 / 4 + 4); h = wd_hits;
    wr(5'h0c, 32'h55); wr(5'h0c, 32'haa); idle(6); `CHK(wd_hits, h)
    wr(5'h08, 32'h0);
    wr(5'h00, 32'h10);
    for (r = 1; r < 4; r++) begin
      wr(5'h10, 0); wr(5'h04, 32'h2); wr(5'h10, r); wait_sig(2, 200, n);
      `CHK(n >= tk_cyc(r) - 4 && n <= tk_cyc(r) + 4, 1'b1)
    end
    bus(0, 5'h04, 0); `CHK(q[1], 1'b1)
    wr(5'h10, 0); wr(5'h04, 32'h2); idle(4); `CHK(tick_irq, 1'b0)
    idle(60); `CHK(tick_irq, 1'b0)
    wr(5'h10, 3); idle(20); wr(5'h10, 3); wait_sig(2, 200, n);
    `CHK(n >= tk_cyc(3) - 4, 1'b1)
    wr(5'h10, 0); wr(5'h04, 32'h2); pseudo_stop <= 1'b1; wr(5'h10, 1); idle(40);
    `CHK(tick_irq, 1'b0)
    `CHK(voltage_regulator_enable, 1'b1)
    wr(5'h00, 32'h1010); wait_sig(2, 40, n); `CHK(n < 40, 1'b1)
    pseudo_stop <= 1'b0;
    q = 32'h8;
    for (i = 0; i < 4000 && q[3] !== 1'b0; i++) bus(0, 5'h04, 0);
    `CHK(q[3], 1'b0)
    wr(5'h00, 32'h4e8); pulse_wait; wait_sig(3, 12, n); `CHK(n < 12, 1'b1)
    `CHK(({pll_select, pll_enable, core_clk_en, sys_clk_en, osc_reduce}), 5'b00001)
    @(posedge clk_sys) ext_wake <= 1'b1;
    @(posedge clk_sys) ext_wake <= 1'b0;
    wait_sig(4, 4, n); `CHK(n < 4, 1'b1)
    idle(2);
    `CHK(({wait_active, pll_select, core_clk_en, sys_clk_en, osc_reduce}), 5'b00110)
    wr(5'h00, 32'h0f); pulse_wait; wait_sig(3, 12, n); `CHK(n < 12, 1'b1)
    osc_run <= 1'b0; wait_sig(4, MON + 10, n); `CHK(n < MON + 10, 1'b1)
    idle(2); `CHK(({self_clock_mode, self_clock_irq, pll_enable, pll_select}), 4'b1110)
    osc_run <= 1'b1; wait_sig(6, 9000, n); `CHK(n < 9000, 1'b1)
    `CHK(n >= 2 * 4096 - 4, 1'b1)
    @(posedge clk_sys) por_event <= 1'b1;
    @(posedge clk_sys) por_event <= 1'b0;
    bus(0, 5'h04, 0); `CHK(q[3], 1'b1)
    wr(5'h00, 32'h1); osc_run <= 1'b0; wait_sig(1, MON + 8, n); `CHK(n < MON + 8, 1'b1)
    osc_run <= 1'b1; bus(0, 5'h00, 0); `CHK(q[1:0], 2'b10)
    finish_test;
  end
endmodule
`default_nettype wire
